// ### core/isamb_consts.svh
// constants of the memory board bus slave and its host
`ifndef ISAMB_CONSTS_SVH
`define ISAMB_CONSTS_SVH

// upper address decode, in 128 kbyte units of la[23:17]
`define ISAMB_SRAM_LO 7'h08
`define ISAMB_SRAM_HI 7'h0D
`define ISAMB_BBRAM_LO 7'h0E
`define ISAMB_BBRAM_HI 7'h0F
`define ISAMB_FLASH_LO 7'h10
`define ISAMB_FLASH_HI 7'h2F

// control and status register in i/o space
`define ISAMB_CSR_ADDR 10'h2A0
`define ISAMB_CSR_VPP 0
`define ISAMB_CSR_BLK 1
`define ISAMB_CSR_RGN_LO 2
`define ISAMB_CSR_RGN_HI 3
`define ISAMB_CSR_REF 4
`define ISAMB_CSR_PAD 3'h0

// timing counts in bus clock cycles
`define ISAMB_WAIT_CYC 2
`define ISAMB_CMD_MIN 2
`define ISAMB_RST_CYC 4

`endif

// ### core/isamb_pkg.sv
// types shared by both ends of the memory board bus
package isamb_pkg;

    typedef enum logic [1:0] {
        RG_NONE = 2'b00,
        RG_SRAM = 2'b01,
        RG_BBRAM = 2'b10,
        RG_FLASH = 2'b11
    } isamb_region_type;

    typedef enum logic [1:0] {
        K_MEMR = 2'b00,
        K_MEMW = 2'b01,
        K_IORD = 2'b10,
        K_IOWR = 2'b11
    } isamb_kind_type;

    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_WAIT = 2'b01,
        DS_ACT = 2'b10
    } isamb_dev_state_type;

    typedef enum logic [2:0] {
        HS_RST = 3'b000,
        HS_IDLE = 3'b001,
        HS_ADDR = 3'b010,
        HS_CMD = 3'b011,
        HS_REC = 3'b100
    } isamb_host_state_type;

endpackage

// ### core/isamb_if.sv
// bus wires between host and memory board, with open-drain resolution
`timescale 1ns/100ps

interface isamb_if;
    logic reset_drv;
    logic bale;
    logic [6:0] la;
    logic [19:0] sa;
    logic sbhe_n;
    logic memr_n;
    logic memw_n;
    logic iord_n;
    logic iowr_n;
    logic refresh_n;
    logic aen;
    logic [15:0] h_sd_o;
    logic h_sd_oe;
    logic [15:0] d_sd_o;
    logic [1:0] d_sd_oe;
    logic cs16_o;
    logic cs16_oe;
    logic rdy_o;
    logic rdy_oe;
    logic [15:0] sd;
    logic memcs16_n;
    logic iochrdy;

    // undriven lines float high through the pull-ups
    assign sd[7:0] = d_sd_oe[0] ? d_sd_o[7:0] : (h_sd_oe ? h_sd_o[7:0] : 8'hFF);
    assign sd[15:8] = d_sd_oe[1] ? d_sd_o[15:8] : (h_sd_oe ? h_sd_o[15:8] : 8'hFF);
    assign memcs16_n = cs16_oe ? cs16_o : 1'b1;
    assign iochrdy = rdy_oe ? rdy_o : 1'b1;

    modport host (
        output reset_drv, bale, la, sa, sbhe_n, memr_n, memw_n, iord_n, iowr_n,
        output refresh_n, aen, h_sd_o, h_sd_oe,
        input sd, memcs16_n, iochrdy
    );

    modport dev (
        input reset_drv, bale, la, sa, sbhe_n, memr_n, memw_n, iord_n, iowr_n,
        input refresh_n, aen, sd,
        output d_sd_o, d_sd_oe, cs16_o, cs16_oe, rdy_o, rdy_oe
    );
endinterface

// ### core/isamb_mem.sv
// one memory device of the board: word array with byte lane writes
`timescale 1ns/100ps

module isamb_mem #(
    parameter int AW = 10
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [1:0] i_be,
    input wire logic [AW-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata
);
    if (AW < 1 || AW > 19) begin : g_bad_aw
        $error("isamb_mem: AW out of range");
    end

    // one array per byte lane, so each array has a single writing process
    for (genvar b = 0; b < 2; b++) begin : g_lane
        logic [7:0] mem [2**AW];

        always_ff @(posedge i_clk) begin
            if (i_we && i_be[b]) begin
                mem[i_addr] <= i_wdata[b*8 +: 8];
            end
        end

        // asynchronous read; the wait states hide any device latency
        assign o_rdata[b*8 +: 8] = mem[i_addr];
    end
endmodule

// ### core/isamb_board.sv
// memory board end: address decode, wait states, byte steering, flash csr
`timescale 1ns/100ps
`include "isamb_consts.svh"

module isamb_board
    import isamb_pkg::*;
#(
    parameter int AW = 10,
    parameter int WAIT_CYC = `ISAMB_WAIT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    isamb_if.dev bus,
    output logic o_vpp_en,
    output logic [1:0] o_region
);
    logic [6:0] la_q;
    logic [19:0] sa_q;
    logic [6:0] la_now;
    logic [19:0] addr;
    isamb_region_type rgn;
    isamb_region_type rgn_q;
    isamb_dev_state_type st_q;
    logic [7:0] wcnt_q;
    logic mem_rd, mem_wr, io_rd, io_wr;
    logic io_hit, mem_go, io_go, go, any_cmd, fire;
    logic vpp_q, blk_q, ref_q;
    logic [7:0] csr_rd;
    logic [1:0] be;
    logic [15:0] wword;
    logic [15:0] rword;
    logic [15:0] rd [3];
    logic [2:0] we;
    logic [15:0] sd_d;
    logic [1:0] oe_d;
    logic [15:0] sd_q;
    logic [1:0] oe_q;
    logic cs16_q;
    logic rdy_q;

    if (WAIT_CYC < 1 || WAIT_CYC > 255) begin : g_bad_wait
        $error("isamb_board: WAIT_CYC must be 1 to 255");
    end

    function automatic isamb_region_type decode(input logic [6:0] la);
        if (la >= `ISAMB_SRAM_LO && la <= `ISAMB_SRAM_HI) begin
            decode = RG_SRAM;
        end else if (la >= `ISAMB_BBRAM_LO && la <= `ISAMB_BBRAM_HI) begin
            decode = RG_BBRAM;
        end else if (la >= `ISAMB_FLASH_LO && la <= `ISAMB_FLASH_HI) begin
            decode = RG_FLASH;
        end else begin
            decode = RG_NONE;
        end
    endfunction

    // upper lines are garbage outside bale, so only the latch is trusted then
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            la_q <= 7'h00;
            sa_q <= 20'h00000;
        end else if (bus.reset_drv) begin
            la_q <= 7'h00;
            sa_q <= 20'h00000;
        end else if (bus.bale) begin
            la_q <= bus.la;
            sa_q <= bus.sa;
        end
    end

    assign la_now = bus.bale ? bus.la : la_q;
    assign addr = bus.bale ? bus.sa : sa_q;
    assign rgn = decode(la_now);

    assign mem_rd = !bus.memr_n;
    assign mem_wr = !bus.memw_n;
    assign io_rd = !bus.iord_n;
    assign io_wr = !bus.iowr_n;
    // refresh cycles belong to system dram, never to this board
    assign mem_go = (mem_rd || mem_wr) && bus.refresh_n && rgn != RG_NONE;
    assign io_hit = bus.aen && addr[9:0] == `ISAMB_CSR_ADDR;
    assign io_go = io_hit && (io_rd || io_wr);
    assign go = mem_go || io_go;
    assign any_cmd = mem_rd || mem_wr || io_rd || io_wr;
    assign fire = st_q == DS_WAIT && wcnt_q == 8'h00;

    // byte lanes from a0 and sbhe; an odd byte access without sbhe rides on the low lane
    always_comb begin
        be = 2'b00;
        wword = bus.sd;
        unique case ({addr[0], bus.sbhe_n})
            2'b00: be = 2'b11;
            2'b01: be = 2'b01;
            2'b10: be = 2'b10;
            2'b11: begin
                be = 2'b10;
                wword = {bus.sd[7:0], bus.sd[7:0]};
            end
        endcase
    end

    // address bits above AW alias inside each device
    for (genvar g = 0; g < 3; g++) begin : g_dev
        assign we[g] = fire && mem_wr && mem_go && rgn == isamb_region_type'(g + 1)
                       && (g != 2 || vpp_q);
        isamb_mem #(.AW(AW)) u_mem (
            .i_clk(i_clk),
            .i_we(we[g]),
            .i_be(be),
            .i_addr(addr[AW:1]),
            .i_wdata(wword),
            .o_rdata(rd[g])
        );
    end

    assign rword = (rgn == RG_NONE) ? 16'h0000 : rd[2'(rgn) - 2'h1];
    assign csr_rd = {`ISAMB_CSR_PAD, ref_q, rgn_q, blk_q, vpp_q};

    always_comb begin
        sd_d = sd_q;
        oe_d = oe_q;
        if (fire && mem_go && mem_rd) begin
            sd_d = (be == 2'b10 && bus.sbhe_n) ? {rword[15:8], rword[15:8]} : rword;
            oe_d = (be == 2'b10 && bus.sbhe_n) ? 2'b01 : be;
        end else if (fire && io_go && io_rd) begin
            sd_d = {8'h00, csr_rd};
            oe_d = 2'b01;
        end else if (!any_cmd) begin
            oe_d = 2'b00;
        end
    end

    // cycle sequencer: pull ready low for WAIT_CYC cycles, then serve
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= DS_IDLE;
            wcnt_q <= 8'h00;
            rdy_q <= 1'b0;
        end else if (bus.reset_drv) begin
            st_q <= DS_IDLE;
            wcnt_q <= 8'h00;
            rdy_q <= 1'b0;
        end else begin
            unique case (st_q)
                DS_IDLE: begin
                    if (go) begin
                        st_q <= DS_WAIT;
                        wcnt_q <= 8'(WAIT_CYC - 1);
                        rdy_q <= 1'b1;
                    end
                end
                DS_WAIT: begin
                    if (!go) begin
                        st_q <= DS_IDLE;
                        rdy_q <= 1'b0;
                    end else if (wcnt_q == 8'h00) begin
                        st_q <= DS_ACT;
                        rdy_q <= 1'b0;
                    end else begin
                        wcnt_q <= wcnt_q - 8'h01;
                    end
                end
                DS_ACT: begin
                    if (!any_cmd) begin
                        st_q <= DS_IDLE;
                    end
                end
                default: begin
                    st_q <= DS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sd_q <= 16'h0000;
            oe_q <= 2'b00;
        end else if (bus.reset_drv) begin
            sd_q <= 16'h0000;
            oe_q <= 2'b00;
        end else begin
            sd_q <= sd_d;
            oe_q <= oe_d;
        end
    end

    // only during address phase or a memory command on our range
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs16_q <= 1'b0;
        end else if (bus.reset_drv) begin
            cs16_q <= 1'b0;
        end else begin
            cs16_q <= rgn != RG_NONE && bus.refresh_n
                      && (bus.bale || mem_rd || mem_wr);
        end
    end

    // flash voltage enable, blocked-write flag (set wins over clear), status
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vpp_q <= 1'b0;
            blk_q <= 1'b0;
            ref_q <= 1'b0;
            rgn_q <= RG_NONE;
        end else if (bus.reset_drv) begin
            vpp_q <= 1'b0;
            blk_q <= 1'b0;
            ref_q <= 1'b0;
            rgn_q <= RG_NONE;
        end else begin
            if (fire && io_go && io_wr) begin
                vpp_q <= bus.sd[`ISAMB_CSR_VPP];
            end
            if (fire && mem_wr && mem_go && rgn == RG_FLASH && !vpp_q) begin
                blk_q <= 1'b1;
            end else if (fire && io_go && io_wr && bus.sd[`ISAMB_CSR_BLK]) begin
                blk_q <= 1'b0;
            end
            if (!bus.refresh_n && (mem_rd || mem_wr)) begin
                ref_q <= 1'b1;
            end else if (fire && io_go && io_wr && bus.sd[`ISAMB_CSR_REF]) begin
                ref_q <= 1'b0;
            end
            if (fire && mem_go) begin
                rgn_q <= rgn;
            end
        end
    end

    assign bus.d_sd_o = sd_q;
    assign bus.d_sd_oe = oe_q;
    assign bus.cs16_o = 1'b0;
    assign bus.cs16_oe = cs16_q;
    assign bus.rdy_o = 1'b0;
    assign bus.rdy_oe = rdy_q;
    assign o_vpp_en = vpp_q;
    assign o_region = rgn_q;
endmodule

// ### core/isamb_host.sv
// host end: drives bus cycles for a simple request port
`timescale 1ns/100ps
`include "isamb_consts.svh"

module isamb_host
    import isamb_pkg::*;
#(
    parameter int RST_CYC = `ISAMB_RST_CYC,
    parameter int CMD_MIN = `ISAMB_CMD_MIN
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    isamb_if.host bus,
    input wire logic i_req,
    input wire isamb_kind_type i_kind,
    input wire logic [23:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wide,
    input wire logic i_refresh,
    input wire logic i_dma,
    output logic o_busy,
    output logic o_ack,
    output logic [15:0] o_rdata,
    output logic o_cs16
);
    isamb_host_state_type st_q;
    isamb_kind_type kind_q;
    logic [7:0] cnt_q;
    logic rst_q, bale_q, sbhe_n_q, cmd_q, ref_n_q, aen_q, oe_q, busy_q, ack_q, cs16_q;
    logic wide_q;
    logic [6:0] la_q;
    logic [19:0] sa_q;
    logic [15:0] wd_q;
    logic [15:0] rd_q;

    if (RST_CYC < 1 || RST_CYC > 255 || CMD_MIN < 2 || CMD_MIN > 255) begin : g_bad
        $error("isamb_host: RST_CYC or CMD_MIN out of range");
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= HS_RST;
            kind_q <= K_MEMR;
            cnt_q <= 8'h00;
            rst_q <= 1'b1;
            bale_q <= 1'b0;
            sbhe_n_q <= 1'b1;
            cmd_q <= 1'b0;
            ref_n_q <= 1'b1;
            aen_q <= 1'b0;
            oe_q <= 1'b0;
            busy_q <= 1'b1;
            ack_q <= 1'b0;
            cs16_q <= 1'b0;
            wide_q <= 1'b0;
            la_q <= 7'h00;
            sa_q <= 20'h00000;
            wd_q <= 16'h0000;
            rd_q <= 16'h0000;
        end else begin
            ack_q <= 1'b0;
            unique case (st_q)
                HS_RST: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(RST_CYC - 1)) begin
                        rst_q <= 1'b0;
                        busy_q <= 1'b0;
                        cnt_q <= 8'h00;
                        st_q <= HS_IDLE;
                    end
                end
                HS_IDLE: begin
                    if (i_req) begin
                        kind_q <= i_kind;
                        la_q <= i_addr[23:17];
                        sa_q <= i_addr[19:0];
                        wide_q <= i_wide && !i_addr[0];
                        // 8-bit odd memory bytes go on the high lane with sbhe
                        sbhe_n_q <= (i_kind == K_IORD || i_kind == K_IOWR) ? 1'b1
                                    : !(i_wide || i_addr[0]);
                        wd_q <= i_addr[0] ? {i_wdata[7:0], i_wdata[7:0]} : i_wdata;
                        aen_q <= (i_kind == K_IORD || i_kind == K_IOWR) && !i_dma;
                        ref_n_q <= !i_refresh;
                        bale_q <= 1'b1;
                        busy_q <= 1'b1;
                        st_q <= HS_ADDR;
                    end
                end
                HS_ADDR: begin
                    bale_q <= 1'b0;
                    cmd_q <= 1'b1;
                    oe_q <= kind_q == K_MEMW || kind_q == K_IOWR;
                    cnt_q <= 8'h00;
                    st_q <= HS_CMD;
                end
                HS_CMD: begin
                    if (cnt_q != 8'hFF) begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                    if (cnt_q >= 8'(CMD_MIN - 1) && bus.iochrdy) begin
                        cmd_q <= 1'b0;
                        oe_q <= 1'b0;
                        cs16_q <= !bus.memcs16_n;
                        rd_q <= wide_q ? bus.sd
                                : {8'h00, (sa_q[0] ? bus.sd[15:8] : bus.sd[7:0])};
                        ack_q <= 1'b1;
                        st_q <= HS_REC;
                    end
                end
                HS_REC: begin
                    ref_n_q <= 1'b1;
                    aen_q <= 1'b0;
                    busy_q <= 1'b0;
                    st_q <= HS_IDLE;
                end
                default: begin
                    st_q <= HS_RST;
                end
            endcase
        end
    end

    assign bus.reset_drv = rst_q;
    assign bus.bale = bale_q;
    assign bus.la = la_q;
    assign bus.sa = sa_q;
    assign bus.sbhe_n = sbhe_n_q;
    assign bus.memr_n = !(cmd_q && kind_q == K_MEMR);
    assign bus.memw_n = !(cmd_q && kind_q == K_MEMW);
    assign bus.iord_n = !(cmd_q && kind_q == K_IORD);
    assign bus.iowr_n = !(cmd_q && kind_q == K_IOWR);
    assign bus.refresh_n = ref_n_q;
    assign bus.aen = aen_q;
    assign bus.h_sd_o = wd_q;
    assign bus.h_sd_oe = oe_q;
    assign o_busy = busy_q;
    assign o_ack = ack_q;
    assign o_rdata = rd_q;
    assign o_cs16 = cs16_q;
endmodule

// ### dv/isamb_asserts.sv
// concurrent checks on the wires between host and memory board
`timescale 1ns/100ps
`include "isamb_consts.svh"

module isamb_asserts (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic reset_drv,
    input wire logic bale,
    input wire logic [6:0] la,
    input wire logic [19:0] sa,
    input wire logic sbhe_n,
    input wire logic memr_n,
    input wire logic memw_n,
    input wire logic iord_n,
    input wire logic iowr_n,
    input wire logic refresh_n,
    input wire logic aen,
    input wire logic [1:0] d_sd_oe,
    input wire logic cs16_oe,
    input wire logic rdy_oe,
    input wire logic memcs16_n,
    input wire logic iochrdy
);
    logic [6:0] la_q;
    logic mem_hit;
    logic io_hit;

    // upper address is only valid with bale, so keep our own copy
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            la_q <= 7'h00;
        end else if (bale) begin
            la_q <= la;
        end
    end
    assign mem_hit = (la_q >= `ISAMB_SRAM_LO) && (la_q <= `ISAMB_FLASH_HI);
    assign io_hit = aen && (sa[9:0] == `ISAMB_CSR_ADDR);

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_mem_start;
        $fell(memr_n & memw_n) && refresh_n && mem_hit;
    endsequence

    sequence s_io_start;
        $fell(iord_n & iowr_n) && io_hit;
    endsequence

    // wait length fixed at the default board setting of two
    sequence s_wait2;
        rdy_oe [*2] ##1 !rdy_oe;
    endsequence

    a_rst_quiet: assert property (reset_drv |=> (d_sd_oe == 2'h0) && !rdy_oe && !cs16_oe)
        else $error("board drives the bus during bus reset");
    a_wait_mem: assert property (s_mem_start |=> s_wait2)
        else $error("memory cycle wait states wrong");
    a_wait_io: assert property (s_io_start |=> s_wait2)
        else $error("csr cycle wait states wrong");
    a_rd_data: assert property (s_mem_start ##0 !memr_n |-> ##3 (d_sd_oe != 2'h0))
        else $error("read data not driven after wait");
    a_cs16_hit: assert property (s_mem_start |=> !memcs16_n)
        else $error("memcs16 missing in served range");
    a_release_miss: assert property ((!memr_n || !memw_n) && !mem_hit |-> memcs16_n && iochrdy)
        else $error("memcs16 or iochrdy driven outside range");
    a_dma_quiet: assert property ((!iord_n || !iowr_n) && !aen |-> (d_sd_oe == 2'h0) && !rdy_oe)
        else $error("board answered an i/o command with aen low");
    a_refresh_quiet: assert property (!refresh_n && !memr_n |-> (d_sd_oe == 2'h0) && !rdy_oe)
        else $error("board answered a refresh cycle");
    a_hi_lane: assert property (!memr_n && sbhe_n |-> !d_sd_oe[1])
        else $error("high byte driven without sbhe");
    a_host_extend: assert property (!memr_n && !iochrdy |=> !memr_n)
        else $error("host ended read while not ready");
    a_addr_held: assert property ((!memr_n || !memw_n) |-> $stable(sa))
        else $error("address moved during a command");
endmodule

// ### dv/tb.sv
// self-checking bench: host and memory board joined by the bus interface
`timescale 1ns/100ps

module tb;
    import isamb_pkg::*;

    typedef struct packed {
        isamb_kind_type k;
        logic [23:0] a;
        logic [15:0] d;
        logic w;
        logic rf;
        logic dma;
        logic [15:0] m;
        logic [15:0] e;
    } isamb_case_type;

    logic i_clk;
    logic i_rst_n;
    logic i_req;
    isamb_kind_type i_kind;
    logic [23:0] i_addr;
    logic [15:0] i_wdata;
    logic i_wide;
    logic i_refresh;
    logic i_dma;
    logic o_busy;
    logic o_ack;
    logic [15:0] o_rdata;
    logic o_cs16;
    logic o_vpp_en;
    logic [1:0] o_region;
    int bad_count = 0;
    int n_tests = 0;
    isamb_case_type rows [24];

    isamb_if bus ();

    isamb_board u_isamb_board (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .bus(bus),
        .o_vpp_en(o_vpp_en),
        .o_region(o_region)
    );

    isamb_host u_isamb_host (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .bus(bus),
        .i_req(i_req),
        .i_kind(i_kind),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wide(i_wide),
        .i_refresh(i_refresh),
        .i_dma(i_dma),
        .o_busy(o_busy),
        .o_ack(o_ack),
        .o_rdata(o_rdata),
        .o_cs16(o_cs16)
    );

    task automatic stop_test();
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one host request, driven at the falling edge, held for one take edge
    task automatic do_op(input isamb_case_type c);
        int n;
        n = 0;
        while (o_busy !== 1'h0 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        chk(16'(o_busy), 16'h0000);
        i_req = 1'h1;
        i_kind = c.k;
        i_addr = c.a;
        i_wdata = c.d;
        i_wide = c.w;
        i_refresh = c.rf;
        i_dma = c.dma;
        @(negedge i_clk);
        i_req = 1'h0;
        n = 0;
        while (o_ack !== 1'h1 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        chk(16'(o_ack), 16'h0001);
    endtask

    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end

    // ops take five to seven cycles each, so this is far beyond a healthy run
    initial begin
        repeat (5000) @(posedge i_clk);
        bad_count++;
        stop_test();
    end

    initial begin
        rows[0] = '{K_MEMW, 24'h100010, 16'hA55A, 1'h1, 1'h0, 1'h0, 16'h0, 16'h0};
        rows[1] = '{K_MEMR, 24'h100010, 16'h0, 1'h1, 1'h0, 1'h0, 16'hFFFF, 16'hA55A};
        rows[2] = '{K_MEMW, 24'h100011, 16'h00C3, 1'h0, 1'h0, 1'h0, 16'h0, 16'h0};
        rows[3] = '{K_MEMR, 24'h100010, 16'h0, 1'h1, 1'h0, 1'h0, 16'hFFFF, 16'hC35A};
        rows[4] = '{K_MEMR, 24'h100011, 16'h0, 1'h0, 1'h0, 1'h0, 16'h00FF, 16'h00C3};
        rows[5] = '{K_MEMW, 24'h1C0020, 16'h1234, 1'h1, 1'h0, 1'h0, 16'h0, 16'h0};
        rows[6] = '{K_MEMR, 24'h1C0020, 16'h0, 1'h1, 1'h0, 1'h0, 16'hFFFF, 16'h1234};
        rows[7] = '{K_IOWR, 24'h0002A0, 16'h0001, 1'h0, 1'h0, 1'h0, 16'h0, 16'h0};
        rows[8] = '{K_MEMW, 24'h200000, 16'hBEEF, 1'h1, 1'h0, 1'h0, 16'h0, 16'h0};
        rows[9] = '{K_MEMR, 24'h200000, 16'h0, 1'h1, 1'h0, 1'h0, 16'hFFFF, 16'hBEEF};
        rows[10] = '{K_IOWR, 24'h0002A0, 16'h0000, 1'h0, 1'h0, 1'h0, 16'h0, 16'h0};
        rows[11] = '{K_MEMW, 24'h200000, 16'h0000, 1'h1, 1'h0, 1'h0, 16'h0, 16'h0};
        rows[12] = '{K_MEMR, 24'h200000, 16'h0, 1'h1, 1'h0, 1'h0, 16'hFFFF, 16'hBEEF};
        rows[13] = '{K_IORD, 24'h0002A0, 16'h0, 1'h0, 1'h0, 1'h0, 16'h00FF, 16'h000E};
        rows[14] = '{K_IOWR, 24'h0002A0, 16'h0003, 1'h0, 1'h0, 1'h1, 16'h0, 16'h0};
        rows[15] = '{K_IORD, 24'h0002A0, 16'h0, 1'h0, 1'h0, 1'h0, 16'h00FF, 16'h000E};
        rows[16] = '{K_IORD, 24'h0002A0, 16'h0, 1'h0, 1'h0, 1'h1, 16'h00FF, 16'h00FF};
        rows[17] = '{K_MEMR, 24'h100010, 16'h0, 1'h0, 1'h1, 1'h0, 16'h00FF, 16'h00FF};
        rows[18] = '{K_IORD, 24'h0002A0, 16'h0, 1'h0, 1'h0, 1'h0, 16'h00FF, 16'h001E};
        rows[19] = '{K_IOWR, 24'h0002A0, 16'h0012, 1'h0, 1'h0, 1'h0, 16'h0, 16'h0};
        rows[20] = '{K_IORD, 24'h0002A0, 16'h0, 1'h0, 1'h0, 1'h0, 16'h00FF, 16'h000C};
        rows[21] = '{K_MEMR, 24'h000000, 16'h0, 1'h0, 1'h0, 1'h0, 16'h00FF, 16'h00FF};
        rows[22] = '{K_MEMR, 24'h100010, 16'h0, 1'h1, 1'h0, 1'h0, 16'hFFFF, 16'hC35A};
        rows[23] = '{K_MEMR, 24'h100010, 16'h0, 1'h0, 1'h0, 1'h0, 16'h00FF, 16'h005A};
        i_rst_n = 1'h0;
        i_req = 1'h0;
        i_kind = K_MEMR;
        i_addr = 24'h0;
        i_wdata = 16'h0;
        i_wide = 1'h0;
        i_refresh = 1'h0;
        i_dma = 1'h0;
        repeat (20) @(negedge i_clk);
        i_rst_n = 1'h1;
        for (int r = 0; r < 24; r++) begin
            do_op(rows[r]);
            if (rows[r].k == K_MEMR || rows[r].k == K_IORD) begin
                chk(o_rdata & rows[r].m, rows[r].e);
                if (rows[r].m == 16'hFFFF) begin
                    chk(16'(o_cs16), 16'h0001);
                end
            end
        end
        chk(16'(o_region), 16'h0001);
        do_op('{K_IOWR, 24'h0002A0, 16'h0001, 1'h0, 1'h0, 1'h0, 16'h0, 16'h0});
        chk(16'(o_vpp_en), 16'h0001);
        // reset in mid-run: state clears, memory contents are kept
        i_rst_n = 1'h0;
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'h1;
        @(negedge i_clk);
        chk(16'(o_vpp_en), 16'h0000);
        chk(16'(o_region), 16'h0000);
        do_op(rows[22]);
        chk(o_rdata, 16'hC35A);
        stop_test();
    end

    isamb_asserts u_isamb_asserts (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .reset_drv(bus.reset_drv),
        .bale(bus.bale),
        .la(bus.la),
        .sa(bus.sa),
        .sbhe_n(bus.sbhe_n),
        .memr_n(bus.memr_n),
        .memw_n(bus.memw_n),
        .iord_n(bus.iord_n),
        .iowr_n(bus.iowr_n),
        .refresh_n(bus.refresh_n),
        .aen(bus.aen),
        .d_sd_oe(bus.d_sd_oe),
        .cs16_oe(bus.cs16_oe),
        .rdy_oe(bus.rdy_oe),
        .memcs16_n(bus.memcs16_n),
        .iochrdy(bus.iochrdy)
    );
endmodule
